// File: design/tfw_top.sv
// Timer family, watchdogs and system tick behind an AXI4-Lite slave
`timescale 1ns/1ns
module tfw_tmr
  import tfw_pkg::*;
#(
  parameter int W = 16,
  parameter int NCH = 4,
  parameter bit UD = 1'b1,
  parameter bit ENC = 1'b0,
  parameter bit MOT = 1'b0,
  parameter logic [3:0] CMPM = 4'h0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr,
  input wire logic [3:0] widx,
  input wire logic [31:0] wd,
  input wire logic [3:0] ridx,
  output logic [31:0] rdat,
  input wire logic dbg,
  input wire logic pll_tick,
  input wire logic [NT-1:0] trig_all,
  input wire logic [3:0] ch_in,
  output logic [3:0] oc,
  output logic [3:0] ocn,
  output logic trgo_q,
  output logic dma_q
);
  if (W > 32 || W < 2 || NCH > 4) begin : g_bad
    $error("tfw_tmr: unsupported width or channel count");
  end
  logic [15:0] ctrl_q;
  logic [4:0] stat_q;
  logic [W-1:0] psc_q, pcnt_q, arr_q, cnt_q;
  logic [15:0] ccm_q;
  logic [7:0] dt_q;
  logic down_q, e0_q, src, step, wrap, uev, dn, frz, trig, enc, ctr;
  logic [3:0] ccf;
  logic [W-1:0] ccr_w [4];
  logic [1:0] dm;
  logic [3:0] ts;

  // ==========================================================
  // Counter
  assign ts = ctrl_q[C_TSRC+:4];
  assign trig = (ts < 4'(NT)) ? trig_all[ts] : 1'b0;
  assign frz = dbg & ctrl_q[C_FRZ];
  assign enc = ENC & ctrl_q[C_ENC];
  assign dm = UD ? ctrl_q[C_DIR+:2] : 2'h0;
  assign ctr = dm[1] & ~enc;
  always_comb begin
    src = 1'b1;
    if (MOT && ctrl_q[C_PLL]) src = pll_tick;
    if (ctrl_q[C_SMS+:2] == 2'h2) src = trig;
    if (enc) src = ch_in[0] & ~e0_q;
  end
  assign dn = enc ? ~ch_in[1] : (dm == 2'h1 || (ctr && down_q));
  assign step = ctrl_q[C_EN] & ~frz & src & (pcnt_q == psc_q);
  assign wrap = dn ? (cnt_q == '0) : (cnt_q == arr_q);
  assign uev = step & wrap;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      pcnt_q <= '0;
      down_q <= 1'b0;
    end else if (wr && widx == R_CNT) begin
      cnt_q <= wd[W-1:0];
    end else if (ctrl_q[C_SMS+:2] == 2'h1 && trig) begin
      cnt_q <= '0;
      pcnt_q <= '0;
    end else if (ctrl_q[C_EN] && !frz && src) begin
      pcnt_q <= (pcnt_q == psc_q) ? '0 : pcnt_q + 1'b1;
      if (step) begin
        if (ctr && wrap) begin
          down_q <= ~down_q;
          cnt_q <= dn ? cnt_q + 1'b1 : cnt_q - 1'b1;
        end else if (wrap) begin
          cnt_q <= dn ? arr_q : '0;
        end else begin
          cnt_q <= dn ? cnt_q - 1'b1 : cnt_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
    end else if (wr && widx == R_CTRL) begin
      ctrl_q <= wd[15:0];
    end else if (uev && ctrl_q[C_OPM]) begin
      ctrl_q[C_EN] <= 1'b0;
    end else if (ctrl_q[C_SMS+:2] == 2'h3 && trig) begin
      ctrl_q[C_EN] <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psc_q <= '0;
      arr_q <= ARR_RST[W-1:0];
      ccm_q <= '0;
      dt_q <= '0;
    end else if (wr) begin
      if (widx == R_PSC) psc_q <= wd[W-1:0];
      if (widx == R_ARR) arr_q <= wd[W-1:0];
      if (widx == R_CCM) ccm_q <= wd[15:0];
      if (widx == R_DT) dt_q <= wd[7:0];
    end
  end

  // Flags: a new event wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
      trgo_q <= 1'b0;
      dma_q <= 1'b0;
      e0_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~((wr && widx == R_STAT) ? wd[4:0] : 5'h0)) | {ccf, uev};
      trgo_q <= uev;
      dma_q <= uev & ctrl_q[C_DMA];
      e0_q <= ch_in[0];
    end
  end

  // ==========================================================
  // Channels
  for (genvar i = 0; i < 4; i++) begin : g_ch
    if (i < NCH) begin : g_on
      logic [W-1:0] ccr_q;
      logic [1:0] md;
      logic [7:0] dc_q;
      logic ref_q, rp_q, ci_q, oc_q, ocn_q, hit, cap, cen, gate, quiet;
      assign md = ccm_q[4*i+:2];
      assign hit = step && cnt_q == ccr_q;
      assign cap = md == M_CAP && ch_in[i] && !ci_q;
      assign ccf[i] = cap | (md != M_CAP && hit);
      assign cen = CMPM[i] & ccm_q[4*i+2];
      assign gate = MOT ? (ctrl_q[C_MOE] & ~frz) : 1'b1;
      assign quiet = dc_q == 8'h0 && ref_q == rp_q;
      assign ccr_w[i] = ccr_q;
      assign oc[i] = oc_q;
      assign ocn[i] = ocn_q;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ccr_q <= '0;
        end else if (wr && widx == R_CCR + 4'(i)) begin
          ccr_q <= wd[W-1:0];
        end else if (cap) begin
          ccr_q <= cnt_q;
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ref_q <= 1'b0;
          ci_q <= 1'b0;
        end else begin
          ci_q <= ch_in[i];
          case (md)
            M_TGL: if (hit) ref_q <= ~ref_q;
            M_PWM: ref_q <= cnt_q < ccr_q;
            default: ref_q <= 1'b0;
          endcase
        end
      end
      // Dead time holds both legs low after every reference edge when the complementary output is enabled (cen)
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          rp_q <= 1'b0;
          dc_q <= '0;
          oc_q <= 1'b0;
          ocn_q <= 1'b0;
        end else begin
          rp_q <= ref_q;
          if (ref_q != rp_q) dc_q <= dt_q;
          else if (dc_q != 8'h0) dc_q <= dc_q - 8'h1;
          oc_q <= gate & ref_q & (quiet | ~cen);
          ocn_q <= gate & cen & ~ref_q & quiet;
        end
      end
    end else begin : g_off
      assign ccf[i] = 1'b0;
      assign ccr_w[i] = '0;
      assign oc[i] = 1'b0;
      assign ocn[i] = 1'b0;
    end
  end

  always_comb begin
    rdat = '0;
    case (ridx)
      R_CTRL: rdat[15:0] = ctrl_q;
      R_STAT: rdat[4:0] = stat_q;
      R_PSC: rdat[W-1:0] = psc_q;
      R_ARR: rdat[W-1:0] = arr_q;
      R_CNT: rdat[W-1:0] = cnt_q;
      R_CCM: rdat[15:0] = ccm_q;
      R_DT: rdat[7:0] = dt_q;
      default: if (ridx[3]) rdat[W-1:0] = ccr_w[ridx[1:0]];
    endcase
  end
endmodule : tfw_tmr

module tfw_top
  import tfw_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic dbg_halt,
  input wire logic pll_tick,
  input wire logic iw_hw_start,
  input wire logic [4*NT-1:0] ch_in,
  output logic [4*NT-1:0] tmr_oc,
  output logic [4*NT-1:0] tmr_ocn,
  output logic [NT-1:0] tmr_dma,
  output logic [1:0] dac_trig,
  output logic iw_reset,
  output logic ww_reset,
  output logic ww_early,
  output logic tick_irq
);
  logic aw_ok_q, w_ok_q, bad, do_wr, rbad, aw_hs, w_hs, ar_hs;
  logic [ADDR_W-1:0] wa_q;
  logic [31:0] wd_q, rmux;
  logic [3:0] ws_q, wblk, widx, rblk, ridx;
  logic [31:0] trd [NT];
  logic [NT-1:0] trgo;
  logic [4*NT-1:0] ch1_q, ch_q;
  logic dbg1_q, dbg_q, hw1_q, hw_q;

  // ==========================================================
  // AXI4-Lite slave: full-word writes only
  assign aw_hs = awvalid & awready;
  assign w_hs = wvalid & wready;
  assign ar_hs = arvalid & arready;
  assign wblk = wa_q[9:6];
  assign widx = wa_q[5:2];
  assign rblk = araddr[9:6];
  assign ridx = araddr[5:2];
  assign bad = wblk > B_ST || ws_q != 4'hf;
  assign do_wr = aw_ok_q & w_ok_q & ~bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
    end else begin
      awready <= ~(aw_hs | (aw_ok_q & ~do_wr));
      wready <= ~(w_hs | (w_ok_q & ~do_wr));
      if (aw_hs) begin
        aw_ok_q <= 1'b1;
        wa_q <= awaddr;
      end
      if (w_hs) begin
        w_ok_q <= 1'b1;
        wd_q <= wdata;
        ws_q <= wstrb;
      end
      if (do_wr) begin
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= bad ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      arready <= ~(ar_hs | (rvalid & ~rready));
      if (ar_hs) begin
        rvalid <= 1'b1;
        rdata <= rmux;
        rresp <= rbad ? RESP_SLVERR : RESP_OKAY;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ch1_q, ch_q, dbg1_q, dbg_q, hw1_q, hw_q} <= '0;
    end else begin
      ch1_q <= ch_in;
      ch_q <= ch1_q;
      dbg1_q <= dbg_halt;
      dbg_q <= dbg1_q;
      hw1_q <= iw_hw_start;
      hw_q <= hw1_q;
    end
  end

  // ==========================================================
  // Timers: motor a/b, wide, gp b/c, mid dual, mid single a/b, basic a/b
  for (genvar t = 0; t < NT; t++) begin : g_tmr
    tfw_tmr #(
      .W(T_W[t]),
      .NCH(T_NCH[t]),
      .UD(T_UD[t]),
      .ENC(T_ENC[t]),
      .MOT(T_MOT[t]),
      .CMPM(T_CMP[t])
    ) u_tmr (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr(do_wr && !bad && wblk == 4'(t)),
      .widx(widx),
      .wd(wd_q),
      .ridx(ridx),
      .rdat(trd[t]),
      .dbg(dbg_q),
      .pll_tick(pll_tick),
      .trig_all(trgo),
      .ch_in(ch_q[4*t+:4]),
      .oc(tmr_oc[4*t+:4]),
      .ocn(tmr_ocn[4*t+:4]),
      .trgo_q(trgo[t]),
      .dma_q(tmr_dma[t])
    );
  end
  assign dac_trig = trgo[9:8];

  // ==========================================================
  // Independent watchdog on a 40 kHz tick
  logic [9:0] lsi_q;
  logic [7:0] iw_pr_q, iw_ps_q;
  logic [11:0] iw_rl_q, iw_cnt_q;
  logic [1:0] iw_cfg_q;
  logic [1:0] iw_init_q;
  logic iw_on_q, iw_to_q, iw_key, iw_wr;
  assign iw_wr = do_wr && !bad && wblk == B_IW;
  assign iw_key = iw_wr && widx == IW_KEY;
  always_ff @(posedge aclk) begin
    if (!aresetn) lsi_q <= '0;
    else lsi_q <= (lsi_q == 10'(LSI_DIV - 1)) ? '0 : lsi_q + 10'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iw_pr_q <= '0;
      iw_rl_q <= IW_RL_RST;
      iw_cfg_q <= '0;
    end else if (iw_wr) begin
      if (widx == IW_PR) iw_pr_q <= wd_q[7:0];
      if (widx == IW_RL) iw_rl_q <= wd_q[11:0];
      if (widx == IW_CFG) iw_cfg_q <= wd_q[1:0];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iw_init_q <= 2'h0;
      iw_on_q <= 1'b0;
      iw_cnt_q <= IW_RL_RST;
      iw_ps_q <= '0;
      iw_to_q <= 1'b0;
      iw_reset <= 1'b0;
    end else begin
      // Strap is read once, when the synchroniser holds the pin level
      if (iw_init_q != 2'h3) iw_init_q <= iw_init_q + 2'h1;
      if ((iw_init_q == 2'h2 && hw_q) || (iw_key && wd_q[15:0] == KEY_START)) begin
        iw_on_q <= 1'b1;
      end
      if (iw_key && (wd_q[15:0] == KEY_START || wd_q[15:0] == KEY_RELOAD)) begin
        iw_cnt_q <= iw_rl_q;
        iw_ps_q <= '0;
        iw_to_q <= 1'b0;
      end else if (iw_on_q && lsi_q == 10'(LSI_DIV - 1) && !(dbg_q && iw_cfg_q[0])) begin
        iw_ps_q <= (iw_ps_q == iw_pr_q) ? '0 : iw_ps_q + 8'h1;
        if (iw_ps_q == iw_pr_q) begin
          if (iw_cnt_q == 12'h0) begin
            iw_cnt_q <= iw_rl_q;
            iw_to_q <= 1'b1;
            if (!iw_cfg_q[1]) iw_reset <= 1'b1;
          end else begin
            iw_cnt_q <= iw_cnt_q - 12'h1;
          end
        end
      end
    end
  end

  // ==========================================================
  // Window watchdog
  logic [11:0] ww_div_q;
  logic [6:0] ww_cnt_q, ww_win_q;
  logic ww_act_q, ww_ewie_q, ww_frz_q, ww_ewf_q, ww_wr;
  assign ww_wr = do_wr && !bad && wblk == B_WW;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ww_div_q <= '0;
      ww_cnt_q <= WW_CNT_RST;
      ww_win_q <= WW_WIN_RST;
      {ww_act_q, ww_ewie_q, ww_frz_q, ww_ewf_q, ww_reset, ww_early} <= '0;
    end else begin
      ww_early <= ww_ewf_q & ww_ewie_q;
      if (!(dbg_q && ww_frz_q)) ww_div_q <= ww_div_q + 12'h1;
      if (ww_wr && widx == WW_CFR) begin
        ww_win_q <= wd_q[6:0];
        ww_ewie_q <= wd_q[9];
        ww_frz_q <= wd_q[10];
      end
      if (ww_wr && widx == WW_SR && wd_q[0]) ww_ewf_q <= 1'b0;
      if (ww_wr && widx == WW_CR) begin
        ww_cnt_q <= wd_q[6:0];
        if (wd_q[7]) ww_act_q <= 1'b1;
        if ((ww_act_q || wd_q[7]) && (!wd_q[6] || ww_cnt_q > ww_win_q)) ww_reset <= 1'b1;
      end else if (ww_div_q == 12'(WW_DIV - 1) && !(dbg_q && ww_frz_q)) begin
        ww_cnt_q <= ww_cnt_q - 7'h1;
        if (ww_cnt_q == WW_EARLY) begin
          ww_ewf_q <= 1'b1;
          if (ww_act_q) ww_reset <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // System tick
  logic [2:0] st_div_q;
  logic [23:0] st_load_q, st_val_q;
  logic [2:0] st_ctl_q;
  logic st_flag_q, st_wr, st_tick, st_rd;
  assign st_wr = do_wr && !bad && wblk == B_ST;
  assign st_rd = ar_hs && rblk == B_ST && ridx == ST_CTRL;
  assign st_tick = st_ctl_q[0] & (st_ctl_q[2] | st_div_q == 3'(ST_DIV - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_div_q <= '0;
      st_ctl_q <= '0;
      st_load_q <= '0;
      st_val_q <= '0;
      st_flag_q <= 1'b0;
      tick_irq <= 1'b0;
    end else begin
      st_div_q <= st_div_q + 3'h1;
      tick_irq <= 1'b0;
      if (st_wr && widx == ST_CTRL) st_ctl_q <= wd_q[2:0];
      if (st_wr && widx == ST_LOAD) st_load_q <= wd_q[23:0];
      if (st_rd) st_flag_q <= 1'b0;
      if (st_wr && widx == ST_VAL) begin
        st_val_q <= '0;
        st_flag_q <= 1'b0;
      end else if (st_tick) begin
        st_val_q <= (st_val_q == 24'h0) ? st_load_q : st_val_q - 24'h1;
        if (st_val_q == 24'h1) begin
          st_flag_q <= 1'b1;
          tick_irq <= st_ctl_q[1];
        end
      end
    end
  end

  // ==========================================================
  // Read mux
  always_comb begin
    rmux = '0;
    rbad = 1'b0;
    if (rblk < 4'(NT)) begin
      rmux = trd[rblk];
    end else begin
      case (rblk)
        B_IW: case (ridx)
          IW_PR: rmux[7:0] = iw_pr_q;
          IW_RL: rmux[11:0] = iw_rl_q;
          IW_CNT: rmux[13:0] = {iw_to_q, iw_on_q, iw_cnt_q};
          IW_CFG: rmux[1:0] = iw_cfg_q;
          default: rmux = '0;
        endcase
        B_WW: case (ridx)
          WW_CR: rmux[7:0] = {ww_act_q, ww_cnt_q};
          WW_CFR: rmux[10:0] = {ww_frz_q, ww_ewie_q, 2'h0, ww_win_q};
          WW_SR: rmux[0] = ww_ewf_q;
          default: rmux = '0;
        endcase
        B_ST: case (ridx)
          ST_CTRL: rmux[16:0] = {st_flag_q, 13'h0, st_ctl_q};
          ST_LOAD: rmux[23:0] = st_load_q;
          ST_VAL: rmux[23:0] = st_val_q;
          default: rmux = '0;
        endcase
        default: rbad = 1'b1;
      endcase
    end
  end
endmodule : tfw_top

// File: design/tfw_pkg.sv
// Constants, register map and per-timer shape of the timer and watchdog family
package tfw_pkg;
  localparam int NT = 10;
  localparam int ADDR_W = 10;
  // Timer register indices inside each 64-byte block
  localparam logic [3:0] R_CTRL = 4'h0;
  localparam logic [3:0] R_STAT = 4'h1;
  localparam logic [3:0] R_PSC = 4'h2;
  localparam logic [3:0] R_ARR = 4'h3;
  localparam logic [3:0] R_CNT = 4'h4;
  localparam logic [3:0] R_CCM = 4'h5;
  localparam logic [3:0] R_DT = 4'h6;
  localparam logic [3:0] R_CCR = 4'h8;
  // Timer control field positions
  localparam int C_EN = 0;
  localparam int C_DIR = 1;
  localparam int C_OPM = 3;
  localparam int C_FRZ = 4;
  localparam int C_DMA = 5;
  localparam int C_PLL = 6;
  localparam int C_MOE = 7;
  localparam int C_TSRC = 8;
  localparam int C_SMS = 12;
  localparam int C_ENC = 14;
  localparam logic [31:0] ARR_RST = 32'hffff_ffff;
  localparam logic [1:0] M_CAP = 2'h1;
  localparam logic [1:0] M_TGL = 2'h2;
  localparam logic [1:0] M_PWM = 2'h3;
  // Per-timer shape: motor a/b, wide, gp b/c, mid dual, mid single a/b, basic a/b
  localparam int T_W [NT] = '{16, 16, 32, 16, 16, 16, 16, 16, 16, 16};
  localparam int T_NCH [NT] = '{4, 4, 4, 4, 4, 2, 1, 1, 0, 0};
  localparam bit T_UD [NT] = '{1, 1, 1, 1, 1, 0, 0, 0, 0, 0};
  localparam bit T_ENC [NT] = '{0, 0, 1, 1, 1, 0, 0, 0, 0, 0};
  localparam bit T_MOT [NT] = '{1, 1, 0, 0, 0, 0, 0, 0, 0, 0};
  localparam logic [3:0] T_CMP [NT] = '{4'h7, 4'h7, 4'h0, 4'h0, 4'h0,
    4'h1, 4'h1, 4'h1, 4'h0, 4'h0};
  // Watchdog and tick blocks
  localparam logic [3:0] B_IW = 4'ha;
  localparam logic [3:0] B_WW = 4'hb;
  localparam logic [3:0] B_ST = 4'hc;
  localparam logic [3:0] IW_KEY = 4'h0;
  localparam logic [3:0] IW_PR = 4'h1;
  localparam logic [3:0] IW_RL = 4'h2;
  localparam logic [3:0] IW_CNT = 4'h3;
  localparam logic [3:0] IW_CFG = 4'h4;
  localparam logic [15:0] KEY_RELOAD = 16'haaaa;
  localparam logic [15:0] KEY_START = 16'hcccc;
  localparam logic [11:0] IW_RL_RST = 12'hfff;
  localparam logic [3:0] WW_CR = 4'h0;
  localparam logic [3:0] WW_CFR = 4'h1;
  localparam logic [3:0] WW_SR = 4'h2;
  localparam logic [6:0] WW_CNT_RST = 7'h7f;
  localparam logic [6:0] WW_WIN_RST = 7'h7f;
  localparam logic [6:0] WW_EARLY = 7'h40;
  localparam logic [3:0] ST_CTRL = 4'h0;
  localparam logic [3:0] ST_LOAD = 4'h1;
  localparam logic [3:0] ST_VAL = 4'h2;
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int LSI_HZ = 40_000;
  localparam int LSI_DIV = CLK_HZ / LSI_HZ;
  localparam int WW_DIV = 4096;
  localparam int ST_DIV = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tfw_pkg

// File: verification/tfw_assertions.sv
// Concurrent checks on the timer family top ports
`timescale 1ns/1ns
module tfw_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic iw_reset,
  input wire logic ww_reset,
  input wire logic tick_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Register bus
  sequence s_wtake;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_bwait;
    bvalid && !bready;
  endsequence
  chk_b_resp: assert property (s_wtake |-> ##2 bvalid)
    else $error("write response not two cycles after take");
  chk_b_hold: assert property (s_bwait |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_aw_block: assert property (awvalid && awready |=> !awready)
    else $error("write address taken twice in a row");
  chk_w_block: assert property (wvalid && wready |=> !wready)
    else $error("write data taken twice in a row");
  chk_r_resp: assert property (arvalid && arready |=> rvalid)
    else $error("read data not one cycle after address");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  chk_ar_block: assert property (rvalid |-> !arready)
    else $error("read address taken while data waits");
  // ==========================================
  // Watchdogs and tick
  chk_iw_sticky: assert property (iw_reset |=> iw_reset)
    else $error("independent watchdog reset released");
  chk_ww_sticky: assert property (ww_reset |=> ww_reset)
    else $error("window watchdog reset released");
  chk_tick_pulse: assert property (tick_irq |=> !tick_irq)
    else $error("tick interrupt longer than one cycle");
endmodule : tfw_chk

// File: verification/tb.sv
// Self-checking bench for the timer family top
`timescale 1ns/1ns
module tb;
  import tfw_pkg::*;
  typedef struct packed {
    logic [9:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] x; logic [1:0] r;
  } tfw_row_s;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, tick_irq, iw_reset, ww_reset, ww_early, hw;
  logic [4*NT-1:0] oc, ocn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs, dac_trig;
  logic [NT-1:0] tmr_dma;
  logic [15:0] pv;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  int m;
  tfw_row_s rows [13] = '{
    '{10'h208, 32'h0, 4'hf, 32'h0, RESP_OKAY}, '{10'h20c, 32'h4, 4'hf, 32'h4, RESP_OKAY},
    '{10'h200, 32'h1, 4'hf, 32'h1, RESP_OKAY}, '{10'h148, 32'h0, 4'hf, 32'h0, RESP_OKAY},
    '{10'h14c, 32'h6, 4'hf, 32'h6, RESP_OKAY}, '{10'h140, 32'h21, 4'hf, 32'h21, RESP_OKAY},
    '{10'h08c, 32'hdeadbeef, 4'hf, 32'hdeadbeef, RESP_OKAY},
    '{10'h0cc, 32'h12345678, 4'hf, 32'h5678, RESP_OKAY},
    '{10'h288, 32'h0, 4'h3, 32'hfff, RESP_SLVERR}, '{10'h288, 32'h1002, 4'hf, 32'h2, RESP_OKAY},
    '{10'h284, 32'h100, 4'hf, 32'h0, RESP_OKAY}, '{10'h2c0, 32'h0, 4'h1, 32'h7f, RESP_SLVERR},
    '{10'h340, 32'h1, 4'hf, 32'h0, RESP_SLVERR}};
  assign pv = {ww_early, iw_reset, ww_reset, tick_irq, tmr_dma, dac_trig};
  tfw_top uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .dbg_halt(1'b0), .pll_tick(1'b0), .iw_hw_start(hw), .ch_in('0), .tmr_oc(oc),
    .tmr_ocn(ocn), .tmr_dma(tmr_dma), .dac_trig(dac_trig), .iw_reset(iw_reset),
    .ww_reset(ww_reset), .ww_early(ww_early), .tick_irq(tick_irq));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic pa = 1'b1;
    logic pw = 1'b1;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (awready) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (wready) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [9:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd_reg
  // Cycles between two pulses of one watched bit
  task automatic gap(input int b);
    n = 0;
    do @(posedge aclk); while (!pv[b]);
    do begin
      @(posedge aclk);
      n++;
    end while (!pv[b]);
  endtask : gap
  task automatic wt(input int b, input int lim);
    n = 0;
    while (!pv[b] && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask : wt
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // ==========================================
  // Sequence
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, hw} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].s);
      chk(rs, rows[i].r);
      rd_reg(rows[i].a);
      chk(rd, rows[i].x);
      chk(rs, (rows[i].a >= 10'h340) ? RESP_SLVERR : RESP_OKAY);
    end
    $display("test registers done");
    gap(0);
    chk(n, 5);
    gap(7);
    chk(n, 7);
    wr(10'h1cc, 32'h3);
    wr(10'h1e0, 32'h2);
    wr(10'h1d4, 32'h7);
    wr(10'h1c0, 32'h1);
    repeat (6) @(posedge aclk);
    n = 0;
    m = 0;
    repeat (8) begin
      @(posedge aclk);
      n += oc[28];
      m += ocn[28];
    end
    chk(n, 2);
    chk(m, 2);
    $display("test timers done");
    wr(10'h304, 32'hff000003);
    wr(10'h300, 32'h7);
    gap(12);
    chk(n, 4);
    wr(10'h300, 32'h5);
    repeat (2) @(posedge aclk);
    wt(12, 20);
    chk(n, 20);
    $display("test tick done");
    wr(10'h2c0, 32'hff);
    wr(10'h2c0, 32'hbf);
    wt(13, 8);
    chk(pv[13], 1'b1);
    wr(10'h280, 32'hcccc);
    wt(14, 4000);
    chk(n > 600 && n < 2600 && pv[14] === 1'b1, 1'b1);
    $display("test watchdogs done");
    aresetn <= 1'b0;
    hw <= 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(pv[14:13], 2'b00);
    rd_reg(10'h2c0);
    chk(rd, 32'h7f);
    rd_reg(10'h28c);
    chk(rd, 32'h1fff);
    $display("test reset done");
    wr(10'h2c4, 32'h27f);
    wr(10'h2c0, 32'h41);
    wt(15, 9000);
    chk(n > 4096 && n < 8200 && pv[15] === 1'b1, 1'b1);
    chk(pv[13], 1'b0);
    $display("test early warning done");
    finish_test();
  end
endmodule : tb
bind tfw_top tfw_chk u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .iw_reset(iw_reset), .ww_reset(ww_reset), .tick_irq(tick_irq));
